// File: mrzq_map.vh
// Constants for the mode-register write and impedance calibration command block.
`ifndef MRZQ_MAP_VH
`define MRZQ_MAP_VH
`define MRZQ_MA_RESET 8'h3F
`define MRZQ_MA_CAL 8'h0A
`define MRZQ_MA_PAT_A 8'h20
`define MRZQ_MA_PAT_B 8'h28
`define MRZQ_MA_ID 8'h05
`define MRZQ_MA_RO_LAST 8'h08
`define MRZQ_MA_RW_LAST 8'h13
`define MRZQ_CODE_INIT 8'hFF
`define MRZQ_CODE_LONG 8'hAB
`define MRZQ_CODE_SHORT 8'h56
`define MRZQ_CODE_DEFAULT 8'hC3
`define MRZQ_PAT_A 4'h5
`define MRZQ_PAT_B 4'hC
`define MRZQ_CLK_MHZ 50
`define MRZQ_T_MRW_CK 5
`define MRZQ_T_MRR_CK 2
`define MRZQ_T_INIT4_US 1
`define MRZQ_T_IMPEDANCE_CAL_INITIAL_US 1
`define MRZQ_T_IMPEDANCE_CAL_LONG_NS 360
`define MRZQ_T_IMPEDANCE_CAL_SHORT_NS 90
`define MRZQ_T_IMPEDANCE_CAL_DEFAULT_NS 50
`endif

// File: mrzq_edge_sync.v
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module mrzq_edge_sync #(
  parameter W = 1
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Asynchronous input and synchronised outputs.
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out,
  output wire rise_out,
  output wire fall_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  reg prev_reg;

  // Only sync_reg reads the first stage; edges come from the second stage.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[0];
    end
  end

  assign sync_out = sync_reg;
  assign rise_out = sync_reg[0] & ~prev_reg; // Edges come from bit 0 only.
  assign fall_out = ~sync_reg[0] & prev_reg;
endmodule // mrzq_edge_sync

// File: mrzq_cmd.v
// Mode-register write, reset, read patterns and impedance calibration sequencing.
`timescale 1ns/1ps
`include "mrzq_map.vh"
module mrzq_cmd #(
  parameter INIT4_CYC = (`MRZQ_T_INIT4_US * `MRZQ_CLK_MHZ),
  parameter IMPEDANCE_CAL_INITIAL_CYC = (`MRZQ_T_IMPEDANCE_CAL_INITIAL_US * `MRZQ_CLK_MHZ),
  parameter IMPEDANCE_CAL_LONG_CYC = (`MRZQ_T_IMPEDANCE_CAL_LONG_NS * `MRZQ_CLK_MHZ) / 1000,
  parameter IMPEDANCE_CAL_SHORT_CYC = (`MRZQ_T_IMPEDANCE_CAL_SHORT_NS * `MRZQ_CLK_MHZ) / 1000,
  parameter IMPEDANCE_CAL_DEFAULT_CYC = (`MRZQ_T_IMPEDANCE_CAL_DEFAULT_NS * `MRZQ_CLK_MHZ) / 1000,
  parameter [7:0] ID_VALUE = 8'h5A
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Command pins from the controller.
  input wire ck_pin,
  input wire cke_pin,
  input wire cs_n_pin,
  input wire [9:0] ca_pin,
  // Calibration pin strapped to the command supply.
  input wire zq_tied_pin,
  // Read data lanes, enable low while driven.
  output reg [7:0] dq_out,
  output reg dq_oe_n,
  // Internal state.
  output reg mr_busy,
  output reg auto_init,
  output reg zq_active,
  output reg [1:0] zq_impedance,
  output reg [7:0] mr_cfg_addr,
  output reg [7:0] mr_cfg_data
);
  localparam S_IDLE = 5'h01;
  localparam S_MRW = 5'h02;
  localparam S_MRR = 5'h04;
  localparam S_RST = 5'h08;
  localparam S_ZQ = 5'h10;
  localparam IMP_DEF = 2'h0;
  localparam IMP_CAL = 2'h1;
  localparam MRW_CYC = `MRZQ_T_MRW_CK;
  localparam MRR_CYC = `MRZQ_T_MRR_CK;

  wire [13:0] pins_sync;
  // Named slices of the resampled pins; bit 0 is the link clock level.
  wire zq_tied_s = pins_sync[13];
  wire cke_s = pins_sync[12];
  wire cs_n_s = pins_sync[11];
  wire [9:0] ca_s = pins_sync[10:1];
  wire ck_rise;
  wire ck_fall;
  reg [4:0] state_reg;
  reg [15:0] cnt_reg;
  reg [9:0] ca_r_reg;
  reg rise_hit_reg;
  reg [7:0] cal_cmd_reg;
  reg [3:0] pat_reg;
  reg pat_mode_reg;
  reg [2:0] beat_reg;
  reg [1:0] zq_target_reg;
  wire [7:0] ma = {ca_r_reg[9:4], ca_s[1:0]};

  // Strap, enable, chip select, CA bus and link clock all pass the same two stages.
  mrzq_edge_sync #(.W(14)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({zq_tied_pin, cke_pin, cs_n_pin, ca_pin, ck_pin}),
    .sync_out(pins_sync),
    .rise_out(ck_rise),
    .fall_out(ck_fall)
  );

  // Command decode and sequencing.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      ca_r_reg <= 10'h000;
      rise_hit_reg <= 1'b0;
      cal_cmd_reg <= 8'h00;
      mr_cfg_addr <= 8'h00;
      mr_cfg_data <= 8'h00;
      pat_reg <= 4'h0;
      pat_mode_reg <= 1'b0;
      beat_reg <= 3'h0;
      zq_target_reg <= IMP_DEF;
      zq_impedance <= IMP_DEF;
      zq_active <= 1'b0;
      auto_init <= 1'b0;
      mr_busy <= 1'b0;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else begin
      if (zq_tied_s) begin
        zq_impedance <= IMP_DEF;
      end
      case (state_reg)
        S_IDLE: begin
          dq_oe_n <= 1'b1;
          mr_busy <= 1'b0;
          auto_init <= 1'b0;
          if (ck_rise) begin
            ca_r_reg <= ca_s;
            // Chip select low, enable high and CA0..CA2 low is a register access.
            rise_hit_reg <= ~cs_n_s & cke_s & (ca_s[2:0] == 3'h0);
          end else if (ck_fall && rise_hit_reg) begin
            rise_hit_reg <= 1'b0;
            mr_busy <= 1'b1;
            if (!ca_r_reg[3]) begin
              state_reg <= S_MRW;
              cnt_reg <= MRW_CYC[15:0];
              if (ma == `MRZQ_MA_RESET) begin
                state_reg <= S_RST;
                cnt_reg <= INIT4_CYC[15:0];
                auto_init <= 1'b1;
                cal_cmd_reg <= 8'h00;
                mr_cfg_addr <= 8'h00;
                mr_cfg_data <= 8'h00;
                zq_impedance <= IMP_DEF;
              end else if (ma == `MRZQ_MA_CAL) begin
                cal_cmd_reg <= ca_s[9:2];
                if (!zq_tied_s) begin
                  state_reg <= S_ZQ;
                  zq_active <= 1'b1;
                  zq_target_reg <= IMP_CAL;
                  case (ca_s[9:2])
                    `MRZQ_CODE_INIT: cnt_reg <= IMPEDANCE_CAL_INITIAL_CYC[15:0];
                    `MRZQ_CODE_LONG: cnt_reg <= IMPEDANCE_CAL_LONG_CYC[15:0];
                    `MRZQ_CODE_SHORT: cnt_reg <= IMPEDANCE_CAL_SHORT_CYC[15:0];
                    `MRZQ_CODE_DEFAULT: begin
                      cnt_reg <= IMPEDANCE_CAL_DEFAULT_CYC[15:0];
                      zq_target_reg <= IMP_DEF;
                    end
                    default: begin
                      state_reg <= S_MRW;
                      zq_active <= 1'b0;
                    end
                  endcase
                end
              end else if (ma > `MRZQ_MA_RO_LAST && ma <= `MRZQ_MA_RW_LAST) begin
                mr_cfg_addr <= ma;
                mr_cfg_data <= ca_s[9:2];
              end
              // Other addresses are read-only or reserved and change nothing.
            end else begin
              state_reg <= S_MRR;
              beat_reg <= 3'h4;
              cnt_reg <= MRR_CYC[15:0];
              pat_mode_reg <= (ma == `MRZQ_MA_PAT_A) || (ma == `MRZQ_MA_PAT_B);
              if (ma == `MRZQ_MA_PAT_A) begin
                pat_reg <= `MRZQ_PAT_A;
              end else if (ma == `MRZQ_MA_PAT_B) begin
                pat_reg <= `MRZQ_PAT_B;
              end else begin
                pat_reg <= 4'h0;
              end
              if (ma == `MRZQ_MA_CAL) begin
                dq_out <= cal_cmd_reg;
              end else if (ma == mr_cfg_addr) begin
                dq_out <= mr_cfg_data;
              end else if (ma == `MRZQ_MA_ID) begin
                dq_out <= ID_VALUE;
              end else begin
                dq_out <= 8'h00;
              end
            end
          end
        end
        S_MRR: begin
          // One beat per link clock edge; register reads have the first beat already loaded.
          if (ck_rise || ck_fall) begin
            if (beat_reg == 3'h4) begin
              dq_oe_n <= 1'b0;
              dq_out <= pat_mode_reg ? {8{pat_reg[0]}} : dq_out;
            end else begin
              dq_out <= pat_mode_reg ? {8{pat_reg[0]}} : 8'h00;
            end
            // Bit time 0 sits in bit 0 of the pattern, so the pattern shifts right.
            pat_reg <= {1'b0, pat_reg[3:1]};
            if (beat_reg == 3'h0) begin
              state_reg <= S_IDLE;
              dq_oe_n <= 1'b1;
            end else begin
              beat_reg <= beat_reg - 3'h1;
            end
          end
        end
        S_MRW, S_RST, S_ZQ: begin
          // Periods count link clock rises for MRW, reference clocks otherwise.
          if ((state_reg != S_MRW) || ck_rise) begin
            if (cnt_reg <= 16'h0001) begin
              state_reg <= S_IDLE;
              auto_init <= 1'b0;
              if (state_reg == S_ZQ) begin
                zq_active <= 1'b0;
                zq_impedance <= zq_target_reg;
              end
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // mrzq_cmd

// File: mrzq_cmd_sva.sv
// Port checker for the command block.
`timescale 1ns/1ps
module mrzq_cmd_sva (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Watched ports.
  input wire zq_tied_pin,
  input wire dq_oe_n,
  input wire mr_busy,
  input wire auto_init,
  input wire zq_active,
  input wire [7:0] mr_cfg_addr,
  input wire [7:0] mr_cfg_data
);
  // One clock domain for every property.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_burst; $fell(dq_oe_n) |-> !dq_oe_n [*8]; endproperty
  a_burst: assert property (p_burst) else $error("Read burst ended early.");
  // The strap passes two flops, so it must have stood for a while before it binds.
  property p_tied;
    zq_tied_pin && $past(zq_tied_pin) && $past(zq_tied_pin, 2) && !zq_active |=> !zq_active;
  endproperty
  a_tied: assert property (p_tied) else $error("Calibration ran while tied.");
  property p_off; $fell(mr_busy) |=> !zq_active && !auto_init; endproperty
  a_off: assert property (p_off) else $error("Circuitry left on after command.");
  property p_init; auto_init && $past(auto_init) |-> mr_cfg_addr == 8'h00 && mr_cfg_data == 8'h00;
  endproperty
  a_init: assert property (p_init) else $error("Registers not at default in reset.");
  property p_rng; $changed(mr_cfg_addr) |-> mr_cfg_addr == 8'h00 || mr_cfg_addr inside {[8'h09:8'h13]};
  endproperty
  a_rng: assert property (p_rng) else $error("Read-only address stored.");
  property p_quiet; !mr_busy && !$past(mr_busy) |-> $stable(mr_cfg_data); endproperty
  a_quiet: assert property (p_quiet) else $error("Data changed without a command.");
  property p_min; $rose(mr_busy) |-> mr_busy [*4]; endproperty
  a_min: assert property (p_min) else $error("Command period too short.");
  property p_hiz; !dq_oe_n |-> !zq_active && !auto_init; endproperty
  a_hiz: assert property (p_hiz) else $error("Data driven during calibration.");
  // Main scenarios.
  c_rd: cover property ($fell(dq_oe_n));
  c_zq: cover property ($rose(zq_active));
  c_rst: cover property ($rose(auto_init));
endmodule // mrzq_cmd_sva
bind mrzq_cmd mrzq_cmd_sva chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .zq_tied_pin(zq_tied_pin),
  .dq_oe_n(dq_oe_n), .mr_busy(mr_busy), .auto_init(auto_init), .zq_active(zq_active),
  .mr_cfg_addr(mr_cfg_addr), .mr_cfg_data(mr_cfg_data));

// File: mrzq_ctrl_model.sv
// Controller model that drives the command pins.
`timescale 1ns/1ps
module mrzq_ctrl_model (
  // Clock.
  input wire ref_clk,
  // Command pins.
  output reg ck_pin,
  output reg cke_pin,
  output reg cs_n_pin,
  output reg [9:0] ca_pin
);
  // Link clock stands low and the bus is idle until a frame.
  initial begin
    ck_pin = 1'b0;
    cke_pin = 1'b1;
    cs_n_pin = 1'b1;
    ca_pin = 10'h000;
  end
  // Hold one link clock half period.
  task step(input reg c, input reg s, input reg [9:0] a);
    begin
      ck_pin <= c;
      cs_n_pin <= s;
      ca_pin <= a;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  // Send rise and fall halves, then release the bus to the inverse value.
  task send(input reg [9:0] r, input reg [9:0] f);
    begin
      @(posedge ref_clk);
      step(1'b0, 1'b0, r);
      step(1'b1, 1'b0, r);
      step(1'b0, 1'b0, f);
      cs_n_pin <= 1'b1;
      ca_pin <= ~f;
      @(posedge ref_clk);
    end
  endtask
  // Clock no-operation periods with a bus that keeps changing.
  task nop(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        step(1'b1, 1'b1, ~ca_pin);
        step(1'b0, 1'b1, ~ca_pin);
      end
    end
  endtask
endmodule // mrzq_ctrl_model

// File: mode_register_write_zq_calibration_bench.sv
// Self-checking bench for the command block.
`timescale 1ns/1ps
`include "mrzq_map.vh"
module mode_register_write_zq_calibration_bench;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg zq_tied_pin = 1'b0;
  wire ck_pin, cke_pin, cs_n_pin, dq_oe_n, mr_busy, auto_init, zq_active;
  wire [9:0] ca_pin;
  wire [7:0] dq_out, mr_cfg_addr, mr_cfg_data;
  wire [1:0] zq_impedance;
  integer err_total = 0;
  integer samples_checked = 0;
  integer k, n;
  // Reference clock at 50 MHz.
  always #10 ref_clk = ~ref_clk;
  mrzq_ctrl_model m (.ref_clk(ref_clk), .ck_pin(ck_pin), .cke_pin(cke_pin),
    .cs_n_pin(cs_n_pin), .ca_pin(ca_pin));
  // Default periods; the calibration default is stretched so every command stays busy four clocks.
  mrzq_cmd #(.IMPEDANCE_CAL_DEFAULT_CYC(4)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ck_pin(ck_pin), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
    .ca_pin(ca_pin), .zq_tied_pin(zq_tied_pin), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .mr_busy(mr_busy), .auto_init(auto_init), .zq_active(zq_active),
    .zq_impedance(zq_impedance), .mr_cfg_addr(mr_cfg_addr), .mr_cfg_data(mr_cfg_data));
  // Print counts and the verdict, then end the run.
  task stop_test;
    begin
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Compare one byte.
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Send a write frame for one register address.
  task wr(input [7:0] a, input [7:0] d);
    m.send({a[7:2], 4'h0}, {d, a[1:0]});
  endtask
  // Clock no-ops until the command period ends.
  task idle;
    begin
      k = 0;
      while (mr_busy !== 1'b0 && k < 80) begin
        m.nop(1);
        k = k + 1;
      end
      if (k == 80) begin
        $display("[FAIL] busy wait ran out");
        err_total = err_total + 1;
        stop_test;
      end
    end
  endtask
  // Writes to writable ends, one refused while busy, one to a read-only place.
  task t_write;
    begin
      wr(8'h13, 8'h3C);
      chk("busy", 8'h01, {7'h00, mr_busy});
      wr(8'h0B, 8'h11);
      idle;
      chk("addr", 8'h13, mr_cfg_addr);
      chk("data", 8'h3C, mr_cfg_data);
      wr(8'h09, 8'hA5);
      idle;
      wr(`MRZQ_MA_ID, 8'hFF);
      idle;
      chk("addr", 8'h09, mr_cfg_addr);
      chk("data", 8'hA5, mr_cfg_data);
    end
  endtask
  // Read a pattern or configuration register and check all four beats.
  task t_read(input [7:0] a, input [31:0] e);
    integer j;
    begin
      m.send({a[7:2], 4'h8}, {8'h00, a[1:0]});
      fork
        m.nop(4);
        begin
          j = 0;
          while (dq_oe_n !== 1'b0 && j < 16) begin
            @(posedge ref_clk);
            j = j + 1;
          end
          if (j == 16) begin
            $display("[FAIL] read burst never started");
            err_total = err_total + 1;
            stop_test;
          end
          repeat (2) @(posedge ref_clk);
          for (j = 0; j < 4; j = j + 1) begin
            chk("beat", e[31-8*j -: 8], dq_out);
            repeat (4) @(posedge ref_clk);
          end
        end
      join
      idle;
      chk("data", 8'hA5, mr_cfg_data);
    end
  endtask
  // Every calibration code, an unknown code, then a code while tied.
  task t_cal;
    reg [63:0] codes;
    reg [7:0] imp, act;
    begin
      codes = {8'hAB, 8'hC3, 8'h56, 8'hC3, 8'hFF, 8'h12, 8'hC3, 8'hFF};
      imp = 8'b10101100;
      act = 8'b10101000;
      for (n = 0; n < 8; n = n + 1) begin
        if (n == 7)
          zq_tied_pin <= 1'b1;
        wr(`MRZQ_MA_CAL, codes[63-8*n -: 8]);
        if (codes[63-8*n -: 8] != `MRZQ_CODE_DEFAULT)
          chk("zq_on", {7'h00, act[7-n]}, {7'h00, zq_active});
        idle;
        chk("zq_off", 8'h00, {7'h00, zq_active});
        chk("imp", {7'h00, imp[7-n]}, {6'h00, zq_impedance});
      end
    end
  endtask
  // Reset write enters auto-initialization and clears the registers.
  task t_reset;
    begin
      wr(`MRZQ_MA_RESET, 8'h00);
      chk("init", 8'h01, {7'h00, auto_init});
      idle;
      chk("init", 8'h00, {7'h00, auto_init});
      chk("addr", 8'h00, mr_cfg_addr);
      chk("data", 8'h00, mr_cfg_data);
    end
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_write;
    t_read(`MRZQ_MA_PAT_A, 32'hFF00FF00);
    t_read(`MRZQ_MA_PAT_B, 32'h0000FFFF);
    t_read(8'h09, 32'hA5000000);
    t_cal;
    t_reset;
    stop_test;
  end
endmodule // mode_register_write_zq_calibration_bench
